//--- hdl/cbt_map.svh
// Register offsets, field positions, reset values and timing counts of the CAN timing/flag block
`ifndef CBT_MAP_SVH
`define CBT_MAP_SVH
`define CBT_OFF_SEGMENTS 12'h000
`define CBT_OFF_PRESCALE 12'h004
`define CBT_OFF_CONTROL 12'h008
`define CBT_OFF_FLAGS 12'h00C
`define CBT_OFF_ENABLES 12'h010
`define CBT_OFF_COUNTERS 12'h014
`define CBT_OFF_RXBIT 12'h018
`define CBT_BIT_TRIPLE 7
`define CBT_SEG2_HI 6
`define CBT_SEG2_LO 4
`define CBT_SEG1_HI 3
`define CBT_SEG1_LO 0
`define CBT_BIT_WAKE_FLAG 7
`define CBT_BIT_STAT_FLAG 6
`define CBT_RX_STATUS_CODE_HI 5
`define CBT_RX_STATUS_CODE_LO 4
`define CBT_TX_STATUS_CODE_HI 3
`define CBT_TX_STATUS_CODE_LO 2
`define CBT_BIT_INIT_REQUEST 0
`define CBT_BIT_WAKE_EN 1
`define CBT_BIT_SLEEP 2
`define CBT_RST_SEGMENTS 8'h23
`define CBT_RST_PRESCALE 6'h00
`define CBT_RST_FLAGS 8'h00
`define CBT_RST_CONTROL 3'h1
`define CBT_LIM_WARN 9'h060
`define CBT_LIM_PASSIVE 9'h080
`define CBT_LIM_BUSOFF 9'h100
`define CBT_INIT_ACK_NS 16
`define CBT_CLK_NS 8
`define CBT_INIT_ACK_CYC ((`CBT_INIT_ACK_NS + `CBT_CLK_NS - 1) / `CBT_CLK_NS)
`endif

//--- hdl/cbt_pkg.sv
// Types shared by the CAN timing/flag block
package cbt_pkg;
	typedef enum logic [2:0] {
		CBT_SYNC = 3'b001,
		CBT_SEG1 = 3'b010,
		CBT_SEG2 = 3'b100
	} cbt_phase_e;
	typedef logic [1:0] cbt_stat_t;
endpackage : cbt_pkg

//--- hdl/cbt_bit_timer.sv
// Bit timing engine: quantum prescaler, segment sequencing and sampling
`timescale 1ns/1ps
`include "cbt_map.svh"
module cbt_bit_timer (
	// Clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// Configuration
	input wire logic [5:0] quantum_prescaler_i,
	input wire logic [3:0] first_segment_len_i,
	input wire logic [2:0] second_segment_len_i,
	input wire logic triple_sample_select_i,
	input wire logic run_i,
	// Synchronised bus level
	input wire logic rx_i,
	// Result
	output logic rx_bit_o,
	output logic bit_valid_o
);
	cbt_pkg::cbt_phase_e phase_r, phase_nxt;
	logic [5:0] pre_r, pre_nxt;
	logic [3:0] tq_r, tq_nxt;
	logic [2:0] hist_r, hist_nxt;
	logic bit_r, bit_nxt;
	logic valid_r, valid_nxt;
	logic tick;

	function automatic logic majority(input logic [2:0] s);
		majority = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
	endfunction : majority

	// One quantum lasts prescaler code plus one clocks
	assign tick = (pre_r == quantum_prescaler_i);

	always_comb
	begin
		phase_nxt = phase_r;
		pre_nxt = tick ? 6'h00 : pre_r + 6'h01;
		tq_nxt = tq_r;
		hist_nxt = hist_r;
		bit_nxt = bit_r;
		valid_nxt = 1'b0;
		if (!run_i)
		begin
			phase_nxt = cbt_pkg::CBT_SYNC;
			pre_nxt = 6'h00;
			tq_nxt = 4'h0;
		end
		else if (tick)
		begin
			// Shift one sample per quantum so the last three end at the sample point
			hist_nxt = {hist_r[1:0], rx_i};
			// Bit time is one sync quantum plus both segments
			case (phase_r)
				cbt_pkg::CBT_SYNC:
				begin
					phase_nxt = cbt_pkg::CBT_SEG1;
					tq_nxt = 4'h0;
				end
				cbt_pkg::CBT_SEG1:
				begin
					if (tq_r == first_segment_len_i)
					begin
						phase_nxt = cbt_pkg::CBT_SEG2;
						tq_nxt = 4'h0;
						// Sample point ends the first segment
						bit_nxt = triple_sample_select_i ? majority(hist_nxt) : rx_i;
						valid_nxt = 1'b1;
					end
					else
						tq_nxt = tq_r + 4'h1;
				end
				cbt_pkg::CBT_SEG2:
				begin
					if (tq_r == {1'b0, second_segment_len_i})
					begin
						phase_nxt = cbt_pkg::CBT_SYNC;
						tq_nxt = 4'h0;
					end
					else
						tq_nxt = tq_r + 4'h1;
				end
				default:
					phase_nxt = cbt_pkg::CBT_SYNC;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			phase_r <= cbt_pkg::CBT_SYNC;
			pre_r <= 6'h00;
			tq_r <= 4'h0;
			hist_r <= 3'h7;
			bit_r <= 1'b1;
			valid_r <= 1'b0;
		end
		else
		begin
			phase_r <= phase_nxt;
			pre_r <= pre_nxt;
			tq_r <= tq_nxt;
			hist_r <= hist_nxt;
			bit_r <= bit_nxt;
			valid_r <= valid_nxt;
		end
	end

	assign rx_bit_o = bit_r;
	assign bit_valid_o = valid_r;

	sample_single_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(run_i && tick && phase_r == cbt_pkg::CBT_SEG1 && tq_r == first_segment_len_i
		&& !triple_sample_select_i) |=> (bit_r == $past(rx_i)))
		else $error("single sample differs from bus level");
	sample_triple_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(run_i && tick && phase_r == cbt_pkg::CBT_SEG1 && tq_r == first_segment_len_i
		&& triple_sample_select_i) |=> (bit_r == majority({$past(hist_r[1:0]), $past(rx_i)})))
		else $error("triple sample not majority");
	seg2_length_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(phase_r == cbt_pkg::CBT_SEG2 && run_i) |-> (tq_r <= {1'b0, second_segment_len_i}))
		else $error("second segment overran");
	seg1_length_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(phase_r == cbt_pkg::CBT_SEG1 && run_i) |-> (tq_r <= first_segment_len_i))
		else $error("first segment overran");
	quantum_length_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		run_i |-> (pre_r <= quantum_prescaler_i))
		else $error("prescaler overran");
endmodule : cbt_bit_timer

//--- hdl/cbt_status_enc.sv
// Error counter to two-bit bus status encoder
`timescale 1ns/1ps
`include "cbt_map.svh"
module cbt_status_enc (
	// Counters
	input wire logic [8:0] count_i,
	input wire logic [8:0] tec_i,
	// Code
	output cbt_pkg::cbt_stat_t code_o
);
	// Bus-off follows the transmit counter for both codes
	always_comb
	begin
		if (tec_i >= `CBT_LIM_BUSOFF)
			code_o = 2'h3;
		else if (count_i >= `CBT_LIM_PASSIVE)
			code_o = 2'h2;
		else if (count_i >= `CBT_LIM_WARN)
			code_o = 2'h1;
		else
			code_o = 2'h0;
	end
endmodule : cbt_status_enc

//--- hdl/cbt_timing_flags.sv
// CAN bit timing and receiver flag block with APB register slave
//
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "cbt_map.svh"
module cbt_timing_flags (
	// Clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// CAN bus and error counters
	input wire logic can_rx_i,
	input wire logic [8:0] transmit_error_counter_i,
	input wire logic [8:0] receive_error_counter_i,
	// Requests and status
	output logic wakeup_irq_o,
	output logic error_irq_o,
	output logic init_acknowledge_o,
	output logic rx_bit_o,
	output logic rx_bit_valid_o
);
	logic [7:0] seg_r, seg_nxt;
	logic [5:0] presc_r, presc_nxt;
	logic [2:0] ctl_r, ctl_nxt;
	logic wake_flag_r, wake_flag_nxt;
	logic stat_flag_r, stat_flag_nxt;
	logic [1:0] ien_r, ien_nxt;
	logic [3:0] code_r, code_nxt;
	logic ack_r, ack_nxt;
	logic [1:0] ack_cnt_r, ack_cnt_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic ready_r, ready_nxt, err_r, err_nxt;
	logic wirq_r, wirq_nxt, eirq_r, eirq_nxt;
	logic rx_meta_r, rx_sync_r, rx_prev_r;
	logic init_mode, wr, rd, activity;
	cbt_pkg::cbt_stat_t rx_code, tx_code;
	logic rbit, rvalid;

	function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
		hit = (a == off);
	endfunction : hit

	function automatic logic mapped(input logic [11:0] a);
		mapped = hit(a, `CBT_OFF_SEGMENTS) | hit(a, `CBT_OFF_PRESCALE)
			| hit(a, `CBT_OFF_CONTROL) | hit(a, `CBT_OFF_FLAGS)
			| hit(a, `CBT_OFF_ENABLES) | hit(a, `CBT_OFF_COUNTERS)
			| hit(a, `CBT_OFF_RXBIT);
	endfunction : mapped

	// Bus pin passes two flops before use
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			rx_meta_r <= 1'b1;
			rx_sync_r <= 1'b1;
			rx_prev_r <= 1'b1;
		end
		else
		begin
			rx_meta_r <= can_rx_i;
			rx_sync_r <= rx_meta_r;
			rx_prev_r <= rx_sync_r;
		end
	end

	cbt_bit_timer u_timer (
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.quantum_prescaler_i(presc_r),
		.first_segment_len_i(seg_r[`CBT_SEG1_HI:`CBT_SEG1_LO]),
		.second_segment_len_i(seg_r[`CBT_SEG2_HI:`CBT_SEG2_LO]),
		.triple_sample_select_i(seg_r[`CBT_BIT_TRIPLE]),
		.run_i(!init_mode && !ctl_r[`CBT_BIT_SLEEP]),
		.rx_i(rx_sync_r),
		.rx_bit_o(rbit),
		.bit_valid_o(rvalid)
	);

	cbt_status_enc u_rx_enc (
		.count_i(receive_error_counter_i),
		.tec_i(transmit_error_counter_i),
		.code_o(rx_code)
	);

	cbt_status_enc u_tx_enc (
		.count_i(transmit_error_counter_i),
		.tec_i(transmit_error_counter_i),
		.code_o(tx_code)
	);

	assign init_mode = ctl_r[`CBT_BIT_INIT_REQUEST] && ack_r;
	assign wr = psel_i && penable_i && pwrite_i && ready_r;
	assign rd = psel_i && !penable_i && !pwrite_i;
	// Falling edge to dominant while asleep counts as bus activity
	assign activity = rx_prev_r && !rx_sync_r;

	always_comb
	begin
		seg_nxt = seg_r;
		presc_nxt = presc_r;
		ctl_nxt = ctl_r;
		ien_nxt = ien_r;
		wake_flag_nxt = wake_flag_r;
		stat_flag_nxt = stat_flag_r;
		code_nxt = code_r;
		ack_nxt = ack_r;
		ack_cnt_nxt = ack_cnt_r;
		// Acknowledge follows the request after a short settle time
		if (ctl_r[`CBT_BIT_INIT_REQUEST] != ack_r)
		begin
			if (ack_cnt_r == 2'(`CBT_INIT_ACK_CYC - 1))
			begin
				ack_nxt = ctl_r[`CBT_BIT_INIT_REQUEST];
				ack_cnt_nxt = 2'h0;
			end
			else
				ack_cnt_nxt = ack_cnt_r + 2'h1;
		end
		else
			ack_cnt_nxt = 2'h0;
		// Software writes; each register holds one aligned word
		if (wr)
		begin
			if (hit(paddr_i, `CBT_OFF_SEGMENTS) && init_mode)
				seg_nxt = pwdata_i[7:0];
			if (hit(paddr_i, `CBT_OFF_PRESCALE) && init_mode)
				presc_nxt = pwdata_i[5:0];
			if (hit(paddr_i, `CBT_OFF_CONTROL))
				ctl_nxt = pwdata_i[2:0];
			if (hit(paddr_i, `CBT_OFF_ENABLES) && !init_mode)
				ien_nxt = pwdata_i[7:6];
			if (hit(paddr_i, `CBT_OFF_FLAGS) && !init_mode)
			begin
				// Write one clears; the wake set below overrides a wake clear
				if (pwdata_i[`CBT_BIT_WAKE_FLAG])
					wake_flag_nxt = 1'b0;
				if (pwdata_i[`CBT_BIT_STAT_FLAG])
					stat_flag_nxt = 1'b0;
			end
		end
		// Wake-up detection in sleep with enable
		if (ctl_r[`CBT_BIT_SLEEP] && ctl_r[`CBT_BIT_WAKE_EN] && activity)
			wake_flag_nxt = 1'b1;
		// Codes track counters only while no change is pending
		if (!stat_flag_r && ({rx_code, tx_code} != code_r))
		begin
			code_nxt = {rx_code, tx_code};
			stat_flag_nxt = 1'b1;
		end
		// Initialization holds flags and enables at reset, not codes
		if (init_mode)
		begin
			wake_flag_nxt = 1'b0;
			stat_flag_nxt = 1'b0;
			ien_nxt = 2'h0;
		end
	end

	always_comb
	begin
		rdata_nxt = 32'h0000_0000;
		ready_nxt = psel_i && !penable_i;
		err_nxt = psel_i && !penable_i && !mapped(paddr_i);
		if (rd)
		begin
			if (hit(paddr_i, `CBT_OFF_SEGMENTS))
				rdata_nxt[7:0] = seg_r;
			if (hit(paddr_i, `CBT_OFF_PRESCALE))
				rdata_nxt[5:0] = presc_r;
			if (hit(paddr_i, `CBT_OFF_CONTROL))
				rdata_nxt[3:0] = {ack_r, ctl_r};
			if (hit(paddr_i, `CBT_OFF_FLAGS))
				rdata_nxt[7:0] = {wake_flag_r, stat_flag_r, code_r, 2'h0};
			if (hit(paddr_i, `CBT_OFF_ENABLES))
				rdata_nxt[7:0] = {ien_r, 6'h00};
			if (hit(paddr_i, `CBT_OFF_COUNTERS))
				rdata_nxt[24:0] = {receive_error_counter_i, 7'h00, transmit_error_counter_i};
			if (hit(paddr_i, `CBT_OFF_RXBIT))
				rdata_nxt[0] = rbit;
		end
		wirq_nxt = wake_flag_nxt && ien_nxt[1];
		eirq_nxt = stat_flag_nxt && ien_nxt[0];
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			seg_r <= `CBT_RST_SEGMENTS;
			presc_r <= `CBT_RST_PRESCALE;
			ctl_r <= `CBT_RST_CONTROL;
			ien_r <= 2'h0;
			wake_flag_r <= 1'b0;
			stat_flag_r <= 1'b0;
			code_r <= 4'h0;
			ack_r <= 1'b0;
			ack_cnt_r <= 2'h0;
			rdata_r <= 32'h0000_0000;
			ready_r <= 1'b0;
			err_r <= 1'b0;
			wirq_r <= 1'b0;
			eirq_r <= 1'b0;
			rx_bit_o <= 1'b1;
			rx_bit_valid_o <= 1'b0;
		end
		else
		begin
			seg_r <= seg_nxt;
			presc_r <= presc_nxt;
			ctl_r <= ctl_nxt;
			ien_r <= ien_nxt;
			wake_flag_r <= wake_flag_nxt;
			stat_flag_r <= stat_flag_nxt;
			code_r <= code_nxt;
			ack_r <= ack_nxt;
			ack_cnt_r <= ack_cnt_nxt;
			rdata_r <= rdata_nxt;
			ready_r <= ready_nxt;
			err_r <= err_nxt;
			wirq_r <= wirq_nxt;
			eirq_r <= eirq_nxt;
			rx_bit_o <= rbit;
			rx_bit_valid_o <= rvalid;
		end
	end

	assign prdata_o = rdata_r;
	assign pready_o = ready_r;
	assign pslverr_o = err_r;
	assign wakeup_irq_o = wirq_r;
	assign error_irq_o = eirq_r;
	assign init_acknowledge_o = ack_r;

	timing_locked_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		!$past(init_mode) |-> $stable(seg_r))
		else $error("timing changed outside initialization");
	codes_frozen_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		$past(stat_flag_r) |-> $stable(code_r))
		else $error("status codes moved while change pending");
	flag_on_change_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(!stat_flag_r && !init_mode && {rx_code, tx_code} != code_r) |=> stat_flag_r)
		else $error("status change not flagged");
	init_hold_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		$past(init_mode) |-> (!wake_flag_r && !stat_flag_r && ien_r == 2'h0))
		else $error("flags not held during initialization");
	zero_write_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(wr && hit(paddr_i, `CBT_OFF_FLAGS) && !pwdata_i[`CBT_BIT_WAKE_FLAG]
		&& wake_flag_r && !init_mode) |=> wake_flag_r)
		else $error("zero write cleared wake flag");
	wake_set_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(ctl_r[`CBT_BIT_SLEEP] && ctl_r[`CBT_BIT_WAKE_EN] && activity && !init_mode)
		|=> wake_flag_r)
		else $error("wake activity not flagged");
	wake_irq_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(wake_flag_r && ien_r[1]) |-> wirq_r)
		else $error("wake request missing");
	err_irq_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(stat_flag_r && ien_r[0]) |-> eirq_r)
		else $error("error request missing");
endmodule : cbt_timing_flags

//--- verif/cbt_bus_node.sv
// Remote CAN node that drives the receive line of the block
`timescale 1ns/1ps
module cbt_bus_node (
	// Clock
	input wire logic clk_i,
	// Bus line, recessive high
	output logic can_rx_o
);
	initial can_rx_o = 1'b1;
	// One level held for a count of cycles, then the bus returns to recessive
	task automatic send_bit(input logic lvl, input int cyc);
		@(posedge clk_i);
		can_rx_o <= lvl;
		repeat (cyc) @(posedge clk_i);
		can_rx_o <= 1'b1;
	endtask : send_bit
endmodule : cbt_bus_node

//--- verif/test_cbt_timing_flags.sv
// Self-checking bench of the CAN timing and receiver flag block
`timescale 1ns/1ps
`include "cbt_map.svh"
module test_cbt_timing_flags;
	logic clk_i, arst_n_i, psel_i, penable_i, pwrite_i, can_rx_i, pready_o, pslverr_o;
	logic wakeup_irq_o, error_irq_o, init_acknowledge_o, rx_bit_o, rx_bit_valid_o;
	logic [11:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o, rd;
	logic [8:0] tx_errs, rx_errs;
	logic [3:0] cd;
	logic sfl, slv, lvl;
	int err_total = 0;
	int checked = 0;
	int seed, n, bt, p;
	logic [8:0] corner [6] = '{9'h05F, 9'h060, 9'h07F, 9'h080, 9'h0FF, 9'h100};

	cbt_timing_flags dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
		.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .can_rx_i(can_rx_i),
		.transmit_error_counter_i(tx_errs), .receive_error_counter_i(rx_errs),
		.wakeup_irq_o(wakeup_irq_o), .error_irq_o(error_irq_o),
		.init_acknowledge_o(init_acknowledge_o), .rx_bit_o(rx_bit_o),
		.rx_bit_valid_o(rx_bit_valid_o));
	cbt_bus_node node (.clk_i(clk_i), .can_rx_o(can_rx_i));

	initial
	begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	// Whole run is well under 20000 cycles
	initial
	begin
		#200000;
		err_total++;
		report_and_stop();
	end

	task automatic report_and_stop();
		$display("checks %0d errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : report_and_stop

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge clk_i);
		psel_i <= 1'b1;
		pwrite_i <= wr;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		k = 0;
		// Request holds until pready is sampled high at a rising edge
		do
		begin
			@(posedge clk_i);
			k++;
		end
		while (pready_o !== 1'b1 && k < 50);
		if (pready_o !== 1'b1)
			err_total++;
		rd = prdata_o;
		slv = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask : apb

	task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(what, rd, exp);
	endtask : rdchk

	task automatic set_mode(input logic [31:0] ctl);
		int k;
		apb(1'b1, `CBT_OFF_CONTROL, ctl);
		k = 0;
		while (init_acknowledge_o !== ctl[0] && k < 20)
		begin
			@(negedge clk_i);
			k++;
		end
		check("init ack", 32'(init_acknowledge_o), 32'(ctl[0]));
	endtask : set_mode

	task automatic wait_valid();
		n = 0;
		do
		begin
			@(posedge clk_i);
			#1;
			n++;
		end
		while (rx_bit_valid_o !== 1'b1 && n < 3000);
	endtask : wait_valid

	function automatic logic [3:0] codes(input logic [8:0] t, input logic [8:0] r);
		logic [1:0] rc, tc;
		tc = t >= 9'h100 ? 2'h3 : t >= 9'h080 ? 2'h2 : t >= 9'h060 ? 2'h1 : 2'h0;
		rc = t >= 9'h100 ? 2'h3 : r >= 9'h080 ? 2'h2 : r >= 9'h060 ? 2'h1 : 2'h0;
		return {rc, tc};
	endfunction : codes

	// Codes follow the counters only while no status change is pending
	task automatic track();
		repeat (3) @(posedge clk_i);
		if (!sfl && codes(tx_errs, rx_errs) != cd)
		begin
			cd = codes(tx_errs, rx_errs);
			sfl = 1'b1;
		end
	endtask : track

	initial
	begin
		seed = 5;
		{arst_n_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
		{tx_errs, rx_errs, cd, sfl} = '0;
		repeat (4) @(posedge clk_i);
		arst_n_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rdchk("segments reset", `CBT_OFF_SEGMENTS, 32'h23);
		rdchk("control reset", `CBT_OFF_CONTROL, 32'h9);
		rdchk("flags reset", `CBT_OFF_FLAGS, 32'h0);
		apb(1'b0, 12'h01C, 32'h0);
		check("unmapped error", 32'(slv), 32'h1);
		for (int i = 0; i < 3; i++)
		begin
			logic [31:0] seg;
			// Only valid codes; triple sampling keeps at least 2 quanta before the sample
			seg = {24'h0, i[0], 3'(1 + {$random(seed)} % 7), 4'(3 + {$random(seed)} % 13)};
			p = {$random(seed)} % 4;
			apb(1'b1, `CBT_OFF_SEGMENTS, seg);
			apb(1'b1, `CBT_OFF_PRESCALE, 32'(p));
			rdchk("segments", `CBT_OFF_SEGMENTS, seg);
			set_mode(32'h0);
			apb(1'b1, `CBT_OFF_SEGMENTS, 32'h5A);
			rdchk("segments locked", `CBT_OFF_SEGMENTS, seg);
			bt = (p + 1) * (3 + seg[6:4] + seg[3:0]);
			lvl = 1'($random(seed));
			fork
				node.send_bit(lvl, 8 * bt);
				begin
					repeat (3) wait_valid();
					check("bit time", 32'(n), 32'(bt));
					check("rx bit", 32'(rx_bit_o), 32'(lvl));
					rdchk("rx bit reg", `CBT_OFF_RXBIT, 32'(lvl));
				end
			join
			set_mode(32'h1);
		end
		set_mode(32'h0);
		for (int i = 0; i < 12; i++)
		begin
			logic [31:0] en;
			en = i[1] ? 32'h40 : 32'h0;
			apb(1'b1, `CBT_OFF_ENABLES, en);
			@(posedge clk_i);
			tx_errs <= i[0] ? 9'($random(seed)) : corner[i / 2];
			rx_errs <= i[0] ? corner[i / 2] : 9'($random(seed));
			track();
			rdchk("flags set", `CBT_OFF_FLAGS, {25'h0, sfl, cd, 2'h0});
			check("error request", 32'(error_irq_o), 32'(sfl & en[6]));
			apb(1'b1, `CBT_OFF_FLAGS, 32'h0);
			@(posedge clk_i);
			tx_errs <= 9'($random(seed));
			track();
			rdchk("codes frozen", `CBT_OFF_FLAGS, {25'h0, sfl, cd, 2'h0});
			apb(1'b1, `CBT_OFF_FLAGS, 32'hFF);
			sfl = 1'b0;
			track();
			rdchk("flags cleared", `CBT_OFF_FLAGS, {25'h0, sfl, cd, 2'h0});
		end
		rdchk("counters", `CBT_OFF_COUNTERS, {7'h0, rx_errs, 7'h0, tx_errs});
		@(posedge clk_i);
		tx_errs <= 9'h100;
		track();
		set_mode(32'h1);
		// Initialization keeps the change flag clear, so codes follow the counters
		sfl = 1'b0;
		track();
		sfl = 1'b0;
		rdchk("flags in init", `CBT_OFF_FLAGS, {26'h0, cd, 2'h0});
		set_mode(32'h0);
		sfl = 1'b0;
		rdchk("flags after init", `CBT_OFF_FLAGS, {26'h0, cd, 2'h0});
		apb(1'b1, `CBT_OFF_ENABLES, 32'h80);
		apb(1'b1, `CBT_OFF_CONTROL, 32'h4);
		node.send_bit(1'b0, 20);
		rdchk("no wake", `CBT_OFF_FLAGS, {26'h0, cd, 2'h0});
		apb(1'b1, `CBT_OFF_CONTROL, 32'h6);
		node.send_bit(1'b0, 20);
		rdchk("wake flag", `CBT_OFF_FLAGS, {24'h0, 2'h2, cd, 2'h0});
		check("wake request", 32'(wakeup_irq_o), 32'h1);
		apb(1'b1, `CBT_OFF_CONTROL, 32'h2);
		apb(1'b1, `CBT_OFF_FLAGS, 32'h80);
		rdchk("wake cleared", `CBT_OFF_FLAGS, {26'h0, cd, 2'h0});
		check("wake request off", 32'(wakeup_irq_o), 32'h0);
		report_and_stop();
	end
endmodule : test_cbt_timing_flags
